//--- include/supply_pin_defines.svh
// constants for the supply output pin control block
`ifndef SUPPLY_PIN_DEFINES_SVH
`define SUPPLY_PIN_DEFINES_SVH
`define CLK_FREQ_HZ        100000000
`define TIMEBASE_FREQ_HZ   20000
`define TIMEBASE_HALF_CYC  (`CLK_FREQ_HZ / (2 * `TIMEBASE_FREQ_HZ))
`define MARGIN_GPO_CHANNELS 12
`define OFS_MODE           12'h000
`define OFS_ENABLE_POL     12'h004
`define OFS_ENABLE_GPO     12'h008
`define OFS_MARGIN_EN      12'h00C
`define OFS_MARGIN_GPO     12'h010
`define OFS_FAULT_ASSERT   12'h014
`define OFS_FAULT_SHUT     12'h018
`define OFS_CONTROL        12'h01C
`define OFS_GPO_LEVEL      12'h020
`define OFS_IRQ_STATUS     12'h024
`define OFS_IRQ_MASK       12'h028
`define OFS_PIN_STATUS     12'h02C
`define OFS_TICK_COUNT     12'h030
`define IRQ_FAULT_SEEN     0
`define IRQ_SHUTDOWN       1
`define IRQ_TIMEBASE_TICK  2
`define CTRL_RECALL_DONE   0
`define CTRL_MONITOR_START 1
`define CTRL_SPARE_GPO     2
`endif

//--- include/supply_pin_pkg.sv
// types for the supply output pin control block
package supply_pin_pkg;
  typedef enum logic [1:0] {ST_HELD, ST_PULL_LOW, ST_MONITOR} fault_phase_t;
  typedef struct packed {
    logic [15:0] chan_fault;
    logic [15:0] seq_enable;
  } chan_events_t;
endpackage

//--- verilog/pin_sync2.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pin_sync2
`default_nettype wire

//--- verilog/supply_output_pin_control.sv
// supply enable, margin, fault line and timebase pin control with apb registers
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "supply_pin_defines.svh"
module supply_output_pin_control #(
  parameter int CHANNELS    = 16,
  parameter int FAULT_LINES = 4,
  parameter int HALF_CYC    = `TIMEBASE_HALF_CYC
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         irq,
  input  wire supply_pin_pkg::chan_events_t chan_in,
  input  wire logic [CHANNELS-1:0]     general_output_func,
  output logic      [CHANNELS-1:0]     supply_enable_out,
  output logic      [CHANNELS-1:0]     supply_enable_oe,
  output logic      [CHANNELS-1:0]     margin_gpo_level,
  output logic      [CHANNELS-1:0]     margin_gpo_oe,
  output logic      [CHANNELS-1:0]     margin_dac_active,
  output logic      [CHANNELS-1:0]     shutdown_req,
  input  wire logic [FAULT_LINES-1:0]  fault_line_in,
  output logic      [FAULT_LINES-1:0]  fault_line_out,
  output logic      [FAULT_LINES-1:0]  fault_line_oe,
  input  wire logic                    timebase_in,
  output logic                         timebase_out,
  output logic                         timebase_oe,
  output logic                         timebase_shared_output,
  output logic                         strap_adjacent_output,
  output logic                         timebase_tick,
  input  wire logic                    reset_pin_in,
  output logic                         reset_pin_out,
  output logic                         reset_pin_oe
);
  // registers
  logic                   device_mode_config;
  logic [CHANNELS-1:0]    enable_pol;
  logic [CHANNELS-1:0]    enable_gpo;
  logic [CHANNELS-1:0]    margin_en;
  logic [CHANNELS-1:0]    margin_gpo;
  logic [31:0]            fault_assert_map;
  logic [31:0]            fault_shut_map;
  logic [2:0]             control;
  logic [CHANNELS-1:0]    gpo_level;
  logic [2:0]             irq_status;
  logic [2:0]             irq_mask;
  logic [15:0]            tick_count;
  supply_pin_pkg::fault_phase_t phase;
  logic [FAULT_LINES-1:0] fault_sync;
  logic [1:0]             tb_sync;
  logic                   tb_prev;
  logic [15:0]            half_cnt;
  logic                   tb_gen;

  // pulled-up pins reset to their idle high level, so no false fault follows reset
  pin_sync2 #(
    .WIDTH     (FAULT_LINES+2),
    .RESET_VAL ({{FAULT_LINES{1'b1}}, 2'b01})
  ) u_pin_sync2 (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({fault_line_in, timebase_in, reset_pin_in}),
    .sync_out ({fault_sync, tb_sync})
  );

  // apb decode
  wire wr_en  = psel & penable & pwrite;
  wire hit_mode = paddr == `OFS_MODE;
  wire hit_pol  = paddr == `OFS_ENABLE_POL;
  wire hit_egpo = paddr == `OFS_ENABLE_GPO;
  wire hit_men  = paddr == `OFS_MARGIN_EN;
  wire hit_mgpo = paddr == `OFS_MARGIN_GPO;
  wire hit_fa   = paddr == `OFS_FAULT_ASSERT;
  wire hit_fs   = paddr == `OFS_FAULT_SHUT;
  wire hit_ctl  = paddr == `OFS_CONTROL;
  wire hit_lvl  = paddr == `OFS_GPO_LEVEL;
  wire hit_ist  = paddr == `OFS_IRQ_STATUS;
  wire hit_imk  = paddr == `OFS_IRQ_MASK;
  wire hit_pin  = paddr == `OFS_PIN_STATUS;
  wire hit_tck  = paddr == `OFS_TICK_COUNT;
  wire mapped   = hit_mode | hit_pol | hit_egpo | hit_men | hit_mgpo | hit_fa | hit_fs
                | hit_ctl | hit_lvl | hit_ist | hit_imk | hit_pin | hit_tck;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = hit_mode ? {31'h0000_0000, device_mode_config}
                 : hit_pol  ? {16'h0000, enable_pol}
                 : hit_egpo ? {16'h0000, enable_gpo}
                 : hit_men  ? {16'h0000, margin_en}
                 : hit_mgpo ? {16'h0000, margin_gpo}
                 : hit_fa   ? fault_assert_map
                 : hit_fs   ? fault_shut_map
                 : hit_ctl  ? {29'h0000_0000, control}
                 : hit_lvl  ? {16'h0000, gpo_level}
                 : hit_ist  ? {29'h0000_0000, irq_status}
                 : hit_imk  ? {29'h0000_0000, irq_mask}
                 : hit_pin  ? {24'h0000_00, tb_sync[1], tb_sync[0], phase, fault_sync}
                 : hit_tck  ? {16'h0000, tick_count}
                 : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_mode_config <= 1'b0;
      enable_pol         <= '1;
      enable_gpo         <= '0;
      margin_en          <= '0;
      margin_gpo         <= '0;
      fault_assert_map   <= 32'h0000_0000;
      fault_shut_map     <= 32'h0000_0000;
      control            <= 3'h0;
      gpo_level          <= '0;
      irq_mask           <= 3'h0;
    end else if (wr_en) begin
      if (hit_mode) device_mode_config <= pwdata[0];
      if (hit_pol)  enable_pol <= pwdata[CHANNELS-1:0];
      if (hit_egpo) enable_gpo <= pwdata[CHANNELS-1:0];
      if (hit_men)  margin_en  <= pwdata[CHANNELS-1:0];
      if (hit_mgpo) margin_gpo <= pwdata[CHANNELS-1:0];
      if (hit_fa)   fault_assert_map <= pwdata;
      if (hit_fs)   fault_shut_map   <= pwdata;
      if (hit_ctl)  control   <= pwdata[2:0];
      if (hit_lvl)  gpo_level <= pwdata[CHANNELS-1:0];
      if (hit_imk)  irq_mask  <= pwdata[2:0];
    end
  end

  // timebase: master divides pclk, slave uses the synchronised pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= 16'h0000;
      tb_gen   <= 1'b0;
      tb_prev  <= 1'b0;
    end else begin
      tb_prev <= tb_sync[1];
      if (half_cnt == 16'(HALF_CYC - 1)) begin
        half_cnt <= 16'h0000;
        tb_gen   <= ~tb_gen;
      end else begin
        half_cnt <= half_cnt + 16'h0001;
      end
    end
  end
  wire master_rise = device_mode_config & (half_cnt == 16'(HALF_CYC - 1)) & ~tb_gen;
  wire slave_rise  = ~device_mode_config & tb_sync[1] & ~tb_prev;
  assign timebase_tick = master_rise | slave_rise;
  assign timebase_out  = tb_gen;
  assign timebase_oe   = device_mode_config & presetn;
  // the shared output always follows general_output_func[0], in master and slave mode alike
  assign timebase_shared_output = general_output_func[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_count <= 16'h0000;
    else if (timebase_tick) tick_count <= tick_count + 16'h0001;
  end

  // fault line phase after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= supply_pin_pkg::ST_HELD;
    end else begin
      case (phase)
        supply_pin_pkg::ST_HELD:
          if (control[`CTRL_RECALL_DONE]) phase <= supply_pin_pkg::ST_PULL_LOW;
        supply_pin_pkg::ST_PULL_LOW:
          if (control[`CTRL_MONITOR_START]) phase <= supply_pin_pkg::ST_MONITOR;
        supply_pin_pkg::ST_MONITOR: phase <= supply_pin_pkg::ST_MONITOR;
        default: phase <= supply_pin_pkg::ST_HELD;
      endcase
    end
  end

  // channels c and c+8 share one map nibble: bit (c % 8) * 4 + line
  logic [FAULT_LINES-1:0] line_demand;
  logic [CHANNELS-1:0]    shut_hit;
  always_comb begin
    line_demand = '0;
    shut_hit    = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      for (int f = 0; f < FAULT_LINES; f++) begin
        if (chan_in.chan_fault[c] && fault_assert_map[(c % 8) * 4 + f]) line_demand[f] = 1'b1;
        if (~fault_sync[f] && fault_shut_map[(c % 8) * 4 + f]) shut_hit[c] = 1'b1;
      end
    end
  end
  assign fault_line_out = '0;
  assign fault_line_oe  = (phase == supply_pin_pkg::ST_PULL_LOW) ? '1
                        : (phase == supply_pin_pkg::ST_MONITOR) ? line_demand
                        : '0;
  assign shutdown_req   = shut_hit;

  // enable and margin outputs
  logic [CHANNELS-1:0] en_lvl;
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      en_lvl[c] = enable_gpo[c] ? (general_output_func[c] ^ gpo_level[c])
                                : (chan_in.seq_enable[c] ~^ enable_pol[c]);
    end
  end
  assign supply_enable_out = en_lvl;
  logic [CHANNELS-1:0] gpo_allowed;
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) gpo_allowed[c] = (c < `MARGIN_GPO_CHANNELS);
  end
  // margining wins over a gpo request on the same channel
  assign margin_dac_active = margin_en;
  assign margin_gpo_level  = general_output_func;
  assign margin_gpo_oe     = presetn ? (margin_gpo & gpo_allowed & ~margin_en) : '0;
  assign supply_enable_oe  = presetn ? '1 : '0;
  assign strap_adjacent_output = control[`CTRL_SPARE_GPO];
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = 1'b0;

  // interrupts: write one to clear, set wins
  wire [2:0] irq_set = {timebase_tick, |shut_hit, ~&fault_sync};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_status <= 3'h0;
    else irq_status <= irq_set | (irq_status & ~((wr_en & hit_ist) ? pwdata[2:0] : 3'h0));
  end
  assign irq = |(irq_status & irq_mask);

  a_fault_release: assert property (@(posedge pclk) disable iff (!presetn)
    phase == supply_pin_pkg::ST_HELD |-> fault_line_oe == '0) else $error("fault held");
  a_fault_pull: assert property (@(posedge pclk) disable iff (!presetn)
    phase == supply_pin_pkg::ST_PULL_LOW |-> &fault_line_oe) else $error("not pulled");
  a_master_oe: assert property (@(posedge pclk) disable iff (!presetn)
    device_mode_config |-> timebase_oe) else $error("no drive");
  a_slave_tick: assert property (@(posedge pclk) disable iff (!presetn)
    !device_mode_config && $rose(tb_sync[1]) |-> timebase_tick) else $error("tick");
  a_margin_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    !margin_en[0] |-> !margin_dac_active[0]) else $error("dac on");
  a_margin_hi: assert property (@(posedge pclk) disable iff (!presetn)
    margin_gpo_oe[15:12] == 4'h0) else $error("high gpo");
  a_monitor_lines: assert property (@(posedge pclk) disable iff (!presetn)
    phase == supply_pin_pkg::ST_MONITOR |-> fault_line_oe == line_demand) else $error("line");
  a_tick_count: assert property (@(posedge pclk) disable iff (!presetn)
    timebase_tick |=> tick_count == $past(tick_count) + 16'h0001) else $error("count");
  c_pull: cover property (@(posedge pclk) phase == supply_pin_pkg::ST_PULL_LOW);
  c_mon: cover property (@(posedge pclk) phase == supply_pin_pkg::ST_MONITOR);
  c_shut: cover property (@(posedge pclk) |shut_hit);
endmodule // supply_output_pin_control
`default_nettype wire

//--- verification/fault_sync_peer.sv
// peer device model on the shared fault lines and the sequencing clock line
`timescale 1ns/100ps
`default_nettype none
module fault_sync_peer #(
  parameter int HALF = 4
) (
  input  wire logic       pclk,
  input  wire logic [3:0] line_oe,
  input  wire logic [3:0] peer_pull,
  input  wire logic       tb_oe,
  input  wire logic       tb_drv,
  input  wire logic       tb_run,
  output logic      [3:0] line_lvl,
  output logic            tb_lvl
);
  logic clk_q = 1'b0;
  int   cnt   = 0;
  // pull-up on each line; any party pulling low wins
  assign line_lvl = ~(line_oe | peer_pull);
  always @(posedge pclk) begin
    if (tb_run && !tb_oe) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) clk_q <= ~clk_q;
    end
  end
  // an undriven line must not look like the last driven level
  assign tb_lvl = tb_oe ? tb_drv : (tb_run ? clk_q : ~clk_q);
endmodule // fault_sync_peer
`default_nettype wire

//--- verification/test_supply_output_pin_control.sv
// self-checking bench for the supply output pin control block
`timescale 1ns/100ps
`default_nettype none
module test_supply_output_pin_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  supply_pin_pkg::chan_events_t chan_in = '0;
  logic [15:0] func = 16'h0000, en_out, en_oe, m_lvl, m_oe, dac_on, shut;
  logic [3:0] f_in, f_out, f_oe, pull = 4'h0;
  logic tb_in, tb_out, tb_oe, tb_sh, strap, tick, rp_out, rp_oe, run = 0, last, se;
  logic [15:0] pol, gsel;
  int err_count = 0, total_checks = 0, n, i;
  supply_output_pin_control #(.HALF_CYC(4)) u_supply_output_pin_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .chan_in(chan_in), .general_output_func(func), .supply_enable_out(en_out),
    .supply_enable_oe(en_oe), .margin_gpo_level(m_lvl), .margin_gpo_oe(m_oe),
    .margin_dac_active(dac_on), .shutdown_req(shut), .fault_line_in(f_in),
    .fault_line_out(f_out), .fault_line_oe(f_oe), .timebase_in(tb_in),
    .timebase_out(tb_out), .timebase_oe(tb_oe), .timebase_shared_output(tb_sh),
    .strap_adjacent_output(strap), .timebase_tick(tick), .reset_pin_in(1'b1),
    .reset_pin_out(rp_out), .reset_pin_oe(rp_oe));
  fault_sync_peer #(.HALF(4)) u_fault_sync_peer (.pclk(pclk), .line_oe(f_oe),
    .peer_pull(pull), .tb_oe(tb_oe), .tb_drv(tb_out), .tb_run(run), .line_lvl(f_in),
    .tb_lvl(tb_in));
  initial forever #5 pclk = ~pclk;
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (int k = 0; k <= 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (k == 20) begin err_count++; test_done(); end
    end
    rd = prdata;
    se = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // expected enable pin level: function when reassigned, else polarity applied
  function automatic logic [15:0] en_model(input logic [15:0] s);
    return (gsel & func) | (~gsel & ~(s ^ pol));
  endfunction
  initial begin
    void'($urandom(32'h351b));
    repeat (3) @(posedge pclk);
    chk({f_oe, m_oe, tb_oe, irq}, 0);
    chk({en_oe, dac_on}, 0);
    chk({rp_oe, rp_out}, 0);
    presetn <= 1;
    apb(1, `OFS_CONTROL, 32'h0000_0005);
    for (i = 0; i < 20 && f_oe !== 4'hf; i++) @(posedge pclk);
    chk(f_oe, 4'hf);
    chk(strap, 1);
    chk(en_oe, 16'hffff);
    apb(1, `OFS_FAULT_ASSERT, 32'h0000_0014);
    apb(1, `OFS_CONTROL, 32'h0000_0003);
    for (i = 0; i < 20 && f_oe !== 4'h0; i++) @(posedge pclk);
    chk(f_oe, 4'h0);
    chk(f_out, 4'h0);
    chan_in.chan_fault <= 16'h0001;
    for (i = 0; i < 20 && f_oe !== 4'h4; i++) @(posedge pclk);
    chk(f_oe, 4'h4);
    chan_in.chan_fault <= 16'h0002;
    for (i = 0; i < 20 && f_oe !== 4'h1; i++) @(posedge pclk);
    chk(f_oe, 4'h1);
    chan_in.chan_fault <= 16'h0000;
    $display("test fault assert done");
    apb(1, `OFS_FAULT_SHUT, 32'h0000_2000);
    apb(1, `OFS_IRQ_MASK, 32'h0000_0003);
    pull <= 4'h1;
    repeat (10) @(posedge pclk);
    chk(shut, 16'h0000);
    pull <= 4'h2;
    for (i = 0; i < 20 && shut !== 16'h0808; i++) @(posedge pclk);
    chk(shut, 16'h0808);
    chk(irq, 1);
    pull <= 4'h0;
    repeat (4) @(posedge pclk);
    apb(1, `OFS_IRQ_STATUS, 32'h0000_0003);
    @(posedge pclk);
    chk(irq, 0);
    $display("test shutdown done");
    repeat (4) begin
      pol = 16'($urandom);
      gsel = 16'($urandom);
      func <= 16'($urandom);
      chan_in.seq_enable <= 16'($urandom);
      apb(1, `OFS_ENABLE_POL, {16'h0000, pol});
      apb(1, `OFS_ENABLE_GPO, {16'h0000, gsel});
      for (i = 0; i < 20 && en_out !== en_model(chan_in.seq_enable); i++) @(posedge pclk);
      chk(en_out, en_model(chan_in.seq_enable));
      chk(tb_sh, func[0]);
      chk(m_lvl, func);
    end
    $display("test enable pins done");
    apb(1, `OFS_MARGIN_EN, 32'h0000_00ff);
    apb(1, `OFS_MARGIN_GPO, 32'h0000_ffff);
    repeat (3) @(posedge pclk);
    chk(dac_on, 16'h00ff);
    chk(m_oe, 16'h0f00);
    apb(1, `OFS_MODE, 32'h0000_0001);
    repeat (16) @(posedge pclk);
    chk(tb_oe, 1);
    n = 0; i = 0; last = tb_out;
    repeat (80) begin
      @(posedge pclk);
      n += tick; i += (tb_out != last); last = tb_out;
    end
    chk(n, 10);
    chk(i, 20);
    apb(1, `OFS_MODE, 32'h0000_0000);
    run <= 1;
    repeat (40) @(posedge pclk);
    chk(tb_oe, 0);
    n = 0;
    repeat (160) begin @(posedge pclk); n += tick; end
    chk(n, 20);
    $display("test timebase done");
    apb(0, 12'hffc, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(se, 1);
    chan_in.chan_fault <= 16'h0001;
    repeat (10) @(posedge pclk);
    presetn <= 0;
    #1 chk(f_oe, 4'h0);
    $display("test reset done");
    test_done();
  end
  initial begin #900000; err_count++; test_done(); end
endmodule // test_supply_output_pin_control
`default_nettype wire
